// [echp_counter.sv]
// counter channel with gating, presets, homing and strobes
`timescale 1ns/1ps
module echp_counter
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        count_up,
  input  wire logic        count_down,
  input  wire logic        gate_in,
  input  wire logic        preload_in,
  input  wire logic [2:0]  strobe_in,
  input  wire logic        marker_in,
  input  wire logic        home_arm,
  output logic [1:0]       preset_out,
  output logic             irq
);
  // ****************************************************
  // input synchronisers
  // ****************************************************
  localparam int NSYNC = 9;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] sync_c;
  wire  [NSYNC-1:0] raw_in = {home_arm, marker_in, strobe_in,
                              preload_in, gate_in, count_down,
                              count_up};

  // [R16] two flops then an edge stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
    end
    else
    begin
      sync_a <= raw_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  wire [NSYNC-1:0] rise = sync_b & ~sync_c;
  wire [NSYNC-1:0] fall = ~sync_b & sync_c;
  wire             gate_lvl = sync_b[2];
  wire             arm_lvl  = sync_b[8];
  wire             pl_edge  = rise[3];
  wire             mk_edge  = rise[7];

  // ****************************************************
  // registers
  // ****************************************************
  logic [31:0]                     ctrl;
  logic [echp_pkg::NUM_EVENT-1:0]  event_flags;
  logic [echp_pkg::NUM_EVENT-1:0]  mask;
  logic signed [31:0]              preload_val;
  logic signed [31:0]              home_val;
  logic signed [31:0]              lo_lim;
  logic signed [31:0]              hi_lim;
  logic signed [31:0]              on_pt [2];
  logic signed [31:0]              off_pt [2];
  logic [15:0]                     div_n;
  logic signed [31:0]              acc;
  logic signed [31:0]              strb [echp_pkg::NUM_STROBE];
  logic [echp_pkg::NUM_STROBE-1:0] strb_valid;
  logic                            home_found;

  wire osc_sel  = ctrl[echp_pkg::CTRL_OSC_BIT];
  wire cont     = ctrl[echp_pkg::CTRL_CONT_BIT];
  wire home_cmd = ctrl[echp_pkg::CTRL_HOME_BIT];
  wire [echp_pkg::NUM_STROBE-1:0] edge_sel =
    ctrl[echp_pkg::CTRL_EDGE_LSB +: echp_pkg::NUM_STROBE];

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ****************************************************
  // apb decode
  // ****************************************************
  wire setup   = psel & ~penable;
  wire access  = psel & penable;
  wire wr_acc  = access & pwrite;
  wire rd_acc  = access & ~pwrite;
  wire ro_hit  = hit(paddr, echp_pkg::OFF_STATUS)
               | hit(paddr, echp_pkg::OFF_EVENT)
               | hit(paddr, echp_pkg::OFF_ACC)
               | hit(paddr, echp_pkg::OFF_STRB0)
               | hit(paddr, echp_pkg::OFF_STRB1)
               | hit(paddr, echp_pkg::OFF_STRB2);
  wire rw_hit  = (paddr[1:0] == 2'h0) && (paddr <= echp_pkg::OFF_DIV)
               && !ro_hit;
  wire mapped  = ro_hit | rw_hit;

  assign pready  = access;
  assign pslverr = access & (!mapped | (pwrite & ro_hit));

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      echp_pkg::OFF_CTRL:    rd_mux = ctrl;
      echp_pkg::OFF_STATUS:  rd_mux = {27'h0, home_found,
                                       1'b0, strb_valid};
      echp_pkg::OFF_EVENT:   rd_mux = {27'h0, event_flags};
      echp_pkg::OFF_MASK:    rd_mux = {27'h0, mask};
      echp_pkg::OFF_PRELOAD: rd_mux = preload_val;
      echp_pkg::OFF_HOMEVAL: rd_mux = home_val;
      echp_pkg::OFF_LOLIM:   rd_mux = lo_lim;
      echp_pkg::OFF_HILIM:   rd_mux = hi_lim;
      echp_pkg::OFF_ON1:     rd_mux = on_pt[0];
      echp_pkg::OFF_OFF1:    rd_mux = off_pt[0];
      echp_pkg::OFF_ON2:     rd_mux = on_pt[1];
      echp_pkg::OFF_OFF2:    rd_mux = off_pt[1];
      echp_pkg::OFF_DIV:     rd_mux = {16'h0, div_n};
      echp_pkg::OFF_ACC:     rd_mux = acc;
      echp_pkg::OFF_STRB0:   rd_mux = strb[0];
      echp_pkg::OFF_STRB1:   rd_mux = strb[1];
      echp_pkg::OFF_STRB2:   rd_mux = strb[2];
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  // read data latched in setup so it stands through access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= rd_mux;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl        <= echp_pkg::RST_CTRL;
      mask        <= '0;
      preload_val <= echp_pkg::RST_ZERO;
      home_val    <= echp_pkg::RST_ZERO;
      lo_lim      <= echp_pkg::RST_ZERO;
      hi_lim      <= echp_pkg::RST_LIM_H;
      on_pt[0]    <= echp_pkg::RST_ZERO;
      on_pt[1]    <= echp_pkg::RST_ZERO;
      off_pt[0]   <= echp_pkg::RST_ZERO;
      off_pt[1]   <= echp_pkg::RST_ZERO;
      div_n       <= echp_pkg::RST_DIV;
    end
    else if (wr_acc)
    begin
      case (paddr)
        echp_pkg::OFF_CTRL:    ctrl <= pwdata;
        echp_pkg::OFF_MASK:    mask <= pwdata[echp_pkg::NUM_EVENT-1:0];
        echp_pkg::OFF_PRELOAD: preload_val <= pwdata;
        echp_pkg::OFF_HOMEVAL: home_val <= pwdata;
        echp_pkg::OFF_LOLIM:   lo_lim <= pwdata;
        echp_pkg::OFF_HILIM:   hi_lim <= pwdata;
        echp_pkg::OFF_ON1:     on_pt[0] <= pwdata;
        echp_pkg::OFF_OFF1:    off_pt[0] <= pwdata;
        echp_pkg::OFF_ON2:     on_pt[1] <= pwdata;
        echp_pkg::OFF_OFF2:    off_pt[1] <= pwdata;
        echp_pkg::OFF_DIV:     div_n <= pwdata[15:0];
        default:               ;
      endcase
    end
  end

  // ****************************************************
  // reference oscillator
  // ****************************************************
  logic [8:0]  pre_cnt;
  logic [15:0] div_cnt;
  logic        osc_tick;
  wire         pre_tick = (pre_cnt == echp_pkg::REF_PRE_MAX);

  // [R8] prescale to reference, then divide by n
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_cnt  <= 9'h000;
      div_cnt  <= 16'h0000;
      osc_tick <= 1'b0;
    end
    else
    begin
      pre_cnt  <= pre_tick ? 9'h000 : 9'(pre_cnt + 9'h001);
      osc_tick <= 1'b0;
      if (pre_tick)
      begin
        if (div_cnt + 16'h0001 >= div_n)
        begin
          div_cnt  <= 16'h0000;
          osc_tick <= 1'b1;
        end
        else
          div_cnt <= 16'(div_cnt + 16'h0001);
      end
    end
  end

  // ****************************************************
  // accumulator
  // ****************************************************
  // [R1] gating input passes counts only with material
  wire up_ev = gate_lvl & (osc_sel ? osc_tick : rise[0]);
  wire dn_ev = gate_lvl & rise[1];
  // [R11] armed homing acts on the marker edge
  wire home_hit = home_cmd & arm_lvl & mk_edge & ~home_found;

  logic signed [31:0] next_acc;
  // [R16] single update per clock, preload first
  always_comb
  begin
    next_acc = acc;
    // [R3] preload edge loads preload value
    if (pl_edge)
      next_acc = preload_val;
    else if (home_hit)
      next_acc = home_val;
    // [R9] up increments, down decrements
    else if (up_ev && !dn_ev)
    begin
      // [R5] wrap upper limit back to lower
      if (acc == hi_lim)
        next_acc = cont ? lo_lim : acc;
      else
        next_acc = acc + 32'sh1;
    end
    else if (dn_ev && !up_ev)
    begin
      if (acc == lo_lim)
        next_acc = cont ? hi_lim : acc;
      else
        next_acc = acc - 32'sh1;
    end
  end

  // [R2] holds its sum between gating intervals
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc <= echp_pkg::RST_ZERO;
    else
      acc <= next_acc;
  end

  // ****************************************************
  // preset outputs
  // ****************************************************
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++)
    begin : g_preset
      // [R4] [R6] [R7] on-point sets, off-point clears
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          preset_out[gp] <= 1'b0;
        else if (acc == off_pt[gp])
          preset_out[gp] <= 1'b0;
        else if (acc == on_pt[gp])
          preset_out[gp] <= 1'b1;
      end
    end
  endgenerate

  // ****************************************************
  // strobes
  // ****************************************************
  logic [echp_pkg::NUM_STROBE-1:0] strb_ev;
  genvar gs;
  generate
    for (gs = 0; gs < echp_pkg::NUM_STROBE; gs++)
    begin : g_strobe
      // [R15] per-strobe edge choice
      assign strb_ev[gs] = edge_sel[gs] ? fall[4+gs] : rise[4+gs];
      wire rd_me = rd_acc &&
        (paddr == 8'(echp_pkg::OFF_STRB0 + 8'(4*gs)));
      // [R14] capture and flag, set beats read clear
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          strb[gs]       <= echp_pkg::RST_ZERO;
          strb_valid[gs] <= 1'b0;
        end
        else if (strb_ev[gs])
        begin
          strb[gs]       <= acc;
          strb_valid[gs] <= 1'b1;
        end
        else if (rd_me)
          strb_valid[gs] <= 1'b0;
      end
    end
  endgenerate

  // ****************************************************
  // homing status
  // ****************************************************
  // [R12] [R13] found after load, dropped with command
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      home_found <= 1'b0;
    else if (!home_cmd)
      home_found <= 1'b0;
    else if (home_hit)
      home_found <= 1'b1;
  end

  // ****************************************************
  // events and interrupt
  // ****************************************************
  wire [echp_pkg::NUM_EVENT-1:0] ev_set = {home_hit, pl_edge, strb_ev};
  wire ev_rd = rd_acc & hit(paddr, echp_pkg::OFF_EVENT);

  // read clears, but a same-cycle event survives
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      event_flags <= '0;
    else
      event_flags <= (ev_rd ? '0 : event_flags) | ev_set;
  end
  assign irq = |(event_flags & mask);
endmodule

// [echp_pkg.sv]
// constants for the homing and preset counter channel
//
// Contract
// [R1] count only while gating input shows material
// [R2] accumulator keeps summing until a preload
// [R3] preload edge loads the preload value
// [R4] two preset outputs switch on at on-point
// [R5] continuous mode cycles lower to upper limit
// [R6] on-point reached asserts that preset output
// [R7] off-point reached releases the preset output
// [R8] reference oscillator divided by programmable divider
// [R9] up pulses increment, down pulses decrement
// [R10] host sets home command before reference
// [R11] armed home loads home value on marker
// [R12] home located shown as status bit 4
// [R13] clearing home command clears home located
// [R14] three strobes capture accumulator and set flag
// [R15] each strobe picks rising or falling edge
// [R16] inputs synchronised, edge detected, one update
package echp_pkg;
  // ****************************************************
  // register byte offsets
  // ****************************************************
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_EVENT   = 8'h08;
  localparam logic [7:0] OFF_MASK    = 8'h0C;
  localparam logic [7:0] OFF_PRELOAD = 8'h10;
  localparam logic [7:0] OFF_HOMEVAL = 8'h14;
  localparam logic [7:0] OFF_LOLIM   = 8'h18;
  localparam logic [7:0] OFF_HILIM   = 8'h1C;
  localparam logic [7:0] OFF_ON1     = 8'h20;
  localparam logic [7:0] OFF_OFF1    = 8'h24;
  localparam logic [7:0] OFF_ON2     = 8'h28;
  localparam logic [7:0] OFF_OFF2    = 8'h2C;
  localparam logic [7:0] OFF_DIV     = 8'h30;
  localparam logic [7:0] OFF_ACC     = 8'h34;
  localparam logic [7:0] OFF_STRB0   = 8'h38;
  localparam logic [7:0] OFF_STRB1   = 8'h3C;
  localparam logic [7:0] OFF_STRB2   = 8'h40;
  // ****************************************************
  // field positions
  // ****************************************************
  localparam int CTRL_OSC_BIT   = 0;
  localparam int CTRL_CONT_BIT  = 1;
  localparam int CTRL_EDGE_LSB  = 2;
  localparam int CTRL_HOME_BIT  = 14;
  localparam int STAT_HOME_BIT  = 4;
  localparam int EV_PRELOAD_BIT = 3;
  localparam int EV_HOME_BIT    = 4;
  localparam int NUM_STROBE     = 3;
  localparam int NUM_EVENT      = 5;
  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [31:0] RST_CTRL  = 32'h0000_0002;
  localparam logic [31:0] RST_LIM_H = 32'h0000_FFFF;
  localparam logic [31:0] RST_ZERO  = 32'h0000_0000;
  localparam logic [15:0] RST_DIV   = 16'h0042;
  // ****************************************************
  // timing
  // ****************************************************
  localparam longint CLK_HZ     = 200000000;
  localparam longint REF_OSC_HZ = 660000;
  localparam int     REF_PRE    = int'(CLK_HZ / REF_OSC_HZ);
  localparam logic [8:0] REF_PRE_MAX = 9'(REF_PRE - 1);
endpackage

// [echp_counter_props.sv]
// port checker for the counter channel
`timescale 1ns/1ps
module echp_counter_props
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  preset_out,
  input wire logic        irq
);
  // ********
  // apb, output and irq checks
  // ********
  wire acc_ph = psel && penable;
  wire rd_set = psel && !penable && !pwrite;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_READY: assert property (pready == acc_ph)
    else $error("pready off access phase");
  AST_ERR_PH: assert property (pslverr |-> acc_ph)
    else $error("pslverr outside access");
  AST_ERR_ALN: assert property (acc_ph && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned not refused");
  AST_ERR_MAP: assert property (acc_ph && paddr > 8'h40 |-> pslverr)
    else $error("unmapped not refused");
  AST_ERR_RO: assert property (acc_ph && pwrite
    && (paddr == echp_pkg::OFF_ACC || paddr == echp_pkg::OFF_STATUS)
    |-> pslverr)
    else $error("read-only write not refused");
  AST_OK_CTRL: assert property (acc_ph && paddr == echp_pkg::OFF_CTRL
    |-> !pslverr)
    else $error("control access refused");
  // read data moves only on a read setup
  AST_RDATA: assert property (!rd_set |=> $stable(prdata))
    else $error("prdata moved without read");
  AST_OUT_RST: assert property ($rose(presetn) |-> preset_out == 2'h0 && !irq)
    else $error("outputs not idle after reset");
  AST_IRQ_OFF: assert property (acc_ph && pwrite
    && paddr == echp_pkg::OFF_MASK && pwdata == 32'h0 |=> !irq)
    else $error("irq with empty mask");
  cover property (acc_ph && pslverr);
  cover property ($rose(preset_out[0]));
  cover property ($rose(preset_out[1]));
  cover property ($rose(irq));
endmodule

bind echp_counter echp_counter_props i_props
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .preset_out, .irq
);

// [echp_enc_model.sv]
// encoder model driving count and marker pulses
`timescale 1ns/1ps
module echp_enc_model
(
  input  wire logic pclk,
  output logic      count_up,
  output logic      count_down,
  output logic      marker_in
);
  initial
  begin
    count_up = 1'b0;
    count_down = 1'b0;
    marker_in = 1'b0;
  end
  // ********
  // pulse train
  // ********
  // two high, three low
  task automatic pulse(input int kind, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      if (kind == 0)
        count_up <= 1'b1;
      else if (kind == 1)
        count_down <= 1'b1;
      else
        marker_in <= 1'b1;
      repeat (2) @(posedge pclk);
      count_up <= 1'b0;
      count_down <= 1'b0;
      marker_in <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask
endmodule

// [test_encoder_counter_home_preset.sv]
// self-checking bench for the counter channel
`timescale 1ns/1ps
module test_encoder_counter_home_preset;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        count_up;
  logic        count_down;
  logic        gate_in = 1'b0;
  logic        preload_in = 1'b0;
  logic [2:0]  strobe_in = 3'h0;
  logic        marker_in;
  logic        home_arm = 1'b0;
  logic [1:0]  preset_out;
  logic        irq;
  logic [31:0] rv;
  logic [31:0] v;
  logic        re;
  int          n;
  int          err_total = 0;
  int          checked = 0;
  always #2.5 pclk = ~pclk;
  echp_counter i_dut
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .count_up, .count_down, .gate_in,
    .preload_in, .strobe_in, .marker_in, .home_arm, .preset_out, .irq
  );
  echp_enc_model i_enc (.pclk, .count_up, .count_down, .marker_in);
  // ********
  // bus, stimulus and compare tasks
  // ********
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  task automatic gate(input logic g);
    gate_in <= g;
    repeat (4) @(posedge pclk);
  endtask
  task automatic pl();
    preload_in <= 1'b1;
    repeat (2) @(posedge pclk);
    preload_in <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic pw(input int k, input logic [1:0] e);
    i_enc.pulse(0, k);
    repeat (2) @(posedge pclk);
    chk({30'h0, preset_out}, {30'h0, e});
  endtask
  task automatic close_out();
    if (err_total == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard, 90000 cycles; a clean run needs under 77000
  initial
  begin
    #450000;
    err_total++;
    close_out();
  end
  // ********
  // test sequence
  // ********
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rdc(echp_pkg::OFF_CTRL, echp_pkg::RST_CTRL);
    rdc(echp_pkg::OFF_HILIM, echp_pkg::RST_LIM_H);
    rdc(echp_pkg::OFF_DIV, {16'h0, echp_pkg::RST_DIV});
    rdc(echp_pkg::OFF_MASK, echp_pkg::RST_ZERO);
    apb(1'b0, 8'h44, 32'h0);
    chk({31'h0, re}, 32'h1);
    apb(1'b0, 8'h02, 32'h0);
    chk({31'h0, re}, 32'h1);
    apb(1'b1, echp_pkg::OFF_ACC, 32'h5);
    chk({31'h0, re}, 32'h1);
    i_enc.pulse(0, 3);
    gate(1'b1);
    i_enc.pulse(0, 4);
    gate(1'b0);
    i_enc.pulse(0, 2);
    gate(1'b1);
    i_enc.pulse(0, 3);
    rdc(echp_pkg::OFF_ACC, 32'h7);
    i_enc.pulse(1, 2);
    rdc(echp_pkg::OFF_ACC, 32'h5);
    pl();
    rdc(echp_pkg::OFF_ACC, 32'h0);
    rdc(echp_pkg::OFF_EVENT, 32'h8);
    apb(1'b1, echp_pkg::OFF_HILIM, 32'd4999);
    apb(1'b1, echp_pkg::OFF_ON1, 32'd4499);
    apb(1'b1, echp_pkg::OFF_ON2, 32'd4999);
    pw(4498, 2'h0);
    pw(1, 2'h1);
    pw(500, 2'h3);
    pw(1, 2'h0);
    rdc(echp_pkg::OFF_ACC, 32'h0);
    apb(1'b1, echp_pkg::OFF_CTRL, 32'h3);
    apb(1'b0, echp_pkg::OFF_ACC, 32'h0);
    v = rv;
    n = 0;
    while (rv === v && n < 8000)
    begin
      apb(1'b0, echp_pkg::OFF_ACC, 32'h0);
      n++;
    end
    v = rv;
    repeat (echp_pkg::REF_PRE * 33) @(posedge pclk);
    rdc(echp_pkg::OFF_ACC, v);
    repeat (echp_pkg::REF_PRE * 66) @(posedge pclk);
    rdc(echp_pkg::OFF_ACC, v + 32'h1);
    apb(1'b1, echp_pkg::OFF_HOMEVAL, 32'h1234);
    apb(1'b1, echp_pkg::OFF_MASK, 32'h10);
    apb(1'b1, echp_pkg::OFF_CTRL, 32'h4002);
    i_enc.pulse(2, 1);
    rdc(echp_pkg::OFF_STATUS, 32'h0);
    home_arm <= 1'b1;
    i_enc.pulse(2, 1);
    rdc(echp_pkg::OFF_ACC, 32'h1234);
    rdc(echp_pkg::OFF_STATUS, 32'h10);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, echp_pkg::OFF_MASK, 32'h0);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, echp_pkg::OFF_MASK, 32'h10);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    rdc(echp_pkg::OFF_EVENT, 32'h10);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, echp_pkg::OFF_CTRL, 32'hA);
    rdc(echp_pkg::OFF_STATUS, 32'h0);
    // strobe 1 captures on its falling edge
    for (int i = 0; i < 3; i++)
    begin
      strobe_in[i] <= 1'b1;
      i_enc.pulse(0, 1);
      strobe_in[i] <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    rdc(echp_pkg::OFF_STATUS, 32'h7);
    rdc(echp_pkg::OFF_STRB0, 32'h1234);
    rdc(echp_pkg::OFF_STRB1, 32'h1236);
    rdc(echp_pkg::OFF_STRB2, 32'h1236);
    rdc(echp_pkg::OFF_STATUS, 32'h0);
    // non-continuous stop at the upper limit after a nonzero preload
    apb(1'b1, echp_pkg::OFF_PRELOAD, 32'd4998);
    apb(1'b1, echp_pkg::OFF_CTRL, 32'h0);
    pl();
    i_enc.pulse(0, 3);
    rdc(echp_pkg::OFF_ACC, 32'd4999);
    // continuous down count wraps from lower to upper limit
    apb(1'b1, echp_pkg::OFF_PRELOAD, 32'h0);
    apb(1'b1, echp_pkg::OFF_CTRL, 32'h2);
    pl();
    i_enc.pulse(1, 1);
    rdc(echp_pkg::OFF_ACC, 32'd4999);
    close_out();
  end
endmodule
